// ### hw/eep_slave.sv
// Two-wire serial slave front end of a 2K-byte nonvolatile memory
//
// Summary of operation
// R1 - Write: word address follows slave address, picks one of 256 words, acknowledged.
// R2 - After word address ack, accept and acknowledge the data byte.
// R3 - Stop ends a write and starts the self-timed internal write.
// R4 - During the internal write ignore the bus and answer nothing.
// R5 - Page write: up to seven more bytes, each acknowledged.
// R6 - Each written byte bumps only the low three address bits.
// R7 - Beyond eight bytes the low counter wraps and overwrites earlier bytes.
// R8 - Slave address is not acknowledged while writing, acknowledged after.
// R9 - Direction bit one selects read: current, random and sequential reads.
// R10 - Address counter holds last accessed address plus one.
// R11 - Read: ack slave address, send a byte, stop transmitting on no-ack.
// R12 - Random read: master writes word address then repeated start with read.
// R13 - Sequential read: next word per master ack, ended by no-ack and stop.
// R14 - Reads increment all eight address bits, wrapping inside the page.
// R15 - Slave address: type code, three page bits, direction bit.
// R16 - Transmitter releases data after eight bits; receiver acks on ninth clock.
// R17 - Internal write lasts at most 10 ms from the stop.
// R18 - No ack after a read byte: stop sending, wait for stop.
// R19 - Page bytes buffered, committed at stop; no data means no write.
`timescale 1ns/1ns
`default_nettype none
module eep_slave #(
    parameter int WR_CYCLES = eep_pkg::WR_CYC
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Serial clock pin, driven by the master
    input  wire logic scl_in,
    // Open-drain serial data pin
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Status
    output logic      wr_busy
);
    import eep_pkg::*;

    localparam int TW = $clog2(WR_CYCLES + 1);

    typedef struct packed {
        eep_state_e     st;
        logic           scl_p;
        logic           sda_p;
        logic [3:0]     bitcnt;
        logic [7:0]     shreg;
        logic           oe;
        logic [2:0]     page;
        logic           rw;
        logic [7:0]     addr;
        logic           mack;
        logic [7:0]     bufm;
        logic [63:0]    pbuf;
        logic [3:0]     cidx;
        logic [TW-1:0]  tmr;
    } eep_state_s;

    eep_state_s q_r;
    eep_state_s q_nxt;
    logic [7:0] mem [0:WORDS-1];

    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0]  rd_byte;
    logic        mem_we;
    logic [10:0] mem_wa;
    logic [7:0]  mem_wd;
    logic        rd_load;

    eep_sync #(.RST_VAL(LINE_IDLE)) u_scl_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .pin_in   (scl_in),
        .pin_sync (scl_s)
    );

    eep_sync #(.RST_VAL(LINE_IDLE)) u_sda_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .pin_in   (sda_in),
        .pin_sync (sda_s)
    );

    assign rise    = scl_s & ~q_r.scl_p;
    assign fall    = ~scl_s & q_r.scl_p;
    // Data moving while the clock stays high marks start and stop
    assign start   = scl_s & q_r.scl_p & q_r.sda_p & ~sda_s;
    assign stop    = scl_s & q_r.scl_p & ~q_r.sda_p & sda_s;
    assign rd_byte = mem[{q_r.page, q_r.addr}];

    // Commit of the page buffer, one slot per cycle at the head of the busy time
    assign mem_we = (q_r.st == ST_BUSY) && !q_r.cidx[3] && q_r.bufm[q_r.cidx[2:0]]; // R19
    assign mem_wa = {q_r.page, q_r.addr[7:3], q_r.cidx[2:0]};
    assign mem_wd = q_r.pbuf[{q_r.cidx[2:0], 3'b000} +: 8];
    assign rd_load = fall && (q_r.bitcnt == 4'd9) && (q_r.st != ST_BUSY) && !start && !stop
                     && ((q_r.st == ST_ADDR && q_r.rw) || (q_r.st == ST_RDATA && q_r.mack));

    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd; // R3
        end
    end

    always_comb begin
        q_nxt       = q_r;
        q_nxt.scl_p = scl_s;
        q_nxt.sda_p = sda_s;
        if (q_r.st == ST_BUSY) begin // R4
            // Bus is deaf here, so acknowledge polling sees no answer
            if (!q_r.cidx[3]) begin
                q_nxt.cidx = q_r.cidx + 4'd1;
            end
            if (q_r.tmr == TW'(WR_CYCLES - 1)) begin // R17
                q_nxt.st   = ST_IDLE;
                q_nxt.bufm = '0;
            end else begin
                q_nxt.tmr = q_r.tmr + TW'(1);
            end
        end else if (start) begin
            // A repeated start drops unfinished write data
            q_nxt.st     = ST_ADDR;
            q_nxt.bitcnt = 4'd0;
            q_nxt.oe     = 1'b0;
            q_nxt.bufm   = '0;
        end else if (stop) begin
            q_nxt.oe = 1'b0;
            if (q_r.st == ST_WDATA && q_r.bufm != 8'h00) begin // R3
                q_nxt.st   = ST_BUSY;
                q_nxt.tmr  = '0;
                q_nxt.cidx = 4'd0;
            end else begin // R19
                q_nxt.st   = ST_IDLE;
                q_nxt.bufm = '0;
            end
        end else if (q_r.st == ST_IDLE || q_r.st == ST_WAIT) begin
            q_nxt.oe = 1'b0; // R18
        end else if (rise) begin
            if (q_r.bitcnt < 4'd8) begin
                q_nxt.shreg  = {q_r.shreg[6:0], sda_s};
                q_nxt.bitcnt = q_r.bitcnt + 4'd1;
            end else if (q_r.bitcnt == 4'd8) begin
                q_nxt.mack   = ~sda_s; // R16
                q_nxt.bitcnt = 4'd9;
            end
        end else if (fall) begin
            if (q_r.bitcnt == 4'd8) begin
                case (q_r.st)
                    ST_ADDR: begin
                        if (q_r.shreg[7:4] == DEV_TYPE) begin // R15
                            q_nxt.page = q_r.shreg[3:1];
                            q_nxt.rw   = q_r.shreg[0]; // R9
                            q_nxt.oe   = 1'b1; // R8
                        end else begin
                            q_nxt.st = ST_WAIT;
                        end
                    end
                    ST_WORD: begin
                        q_nxt.addr = q_r.shreg; // R1
                        q_nxt.oe   = 1'b1; // R1
                    end
                    ST_WDATA: begin
                        q_nxt.pbuf[{q_r.addr[2:0], 3'b000} +: 8] = q_r.shreg; // R7
                        q_nxt.bufm[q_r.addr[2:0]]                = 1'b1; // R19
                        q_nxt.addr[2:0]                          = q_r.addr[2:0] + 3'd1; // R6
                        q_nxt.oe                                 = 1'b1; // R2 R5
                    end
                    default: begin
                        q_nxt.oe = 1'b0; // R16
                    end
                endcase
            end else if (q_r.bitcnt == 4'd9) begin
                q_nxt.bitcnt = 4'd0;
                q_nxt.oe     = 1'b0;
                if (rd_load) begin // R11 R13
                    q_nxt.st    = ST_RDATA;
                    q_nxt.shreg = rd_byte;
                    q_nxt.addr  = q_r.addr + 8'h01; // R10 R14
                    q_nxt.oe    = ~rd_byte[7];
                end else if (q_r.st == ST_ADDR) begin
                    q_nxt.st = ST_WORD;
                end else if (q_r.st == ST_WORD) begin
                    q_nxt.st = ST_WDATA;
                end else if (q_r.st == ST_RDATA) begin
                    q_nxt.st = ST_WAIT; // R18
                end
            end else if (q_r.st == ST_RDATA && q_r.bitcnt != 4'd0) begin
                q_nxt.oe = ~q_r.shreg[7]; // R11
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            // Edge history starts at the idle line level, so no false edge follows reset
            q_r <= '{st: ST_IDLE, scl_p: LINE_IDLE, sda_p: LINE_IDLE, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = q_r.oe;
    assign wr_busy = (q_r.st == ST_BUSY);

    // Helper views for the checks below
    logic [7:0] chk_addr;
    logic [7:0] chk_shreg;
    logic       byte_end;
    assign chk_addr  = q_r.addr;
    assign chk_shreg = q_r.shreg;
    assign byte_end  = fall && (q_r.bitcnt == 4'd8) && !start && !stop;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_busy_silent: assert property (q_r.st == ST_BUSY |-> !sda_oe) // R4
        else $error("data line driven during internal write");
    a_busy_no_ack: assert property (wr_busy ##1 wr_busy |-> $stable(q_r.bitcnt) && !sda_oe) // R8
        else $error("bus activity accepted while busy");
    a_stop_commit: assert property (stop && q_r.st == ST_WDATA && q_r.bufm != 8'h00 |=> wr_busy) // R3
        else $error("stop after data did not start write");
    a_stop_empty: assert property (stop && q_r.st != ST_BUSY && q_r.st != ST_WDATA |=> q_r.st == ST_IDLE) // R19
        else $error("write cycle without data");
    a_addr_ack: assert property (byte_end && q_r.st == ST_ADDR && chk_shreg[7:4] == DEV_TYPE |=> sda_oe) // R15
        else $error("own slave address not acknowledged");
    a_word_load: assert property (byte_end && q_r.st == ST_WORD |=> chk_addr == $past(chk_shreg) && sda_oe) // R1
        else $error("word address not taken");
    a_wr_wrap: assert property (byte_end && q_r.st == ST_WDATA // R6
        |=> chk_addr[7:3] == $past(chk_addr[7:3]) && chk_addr[2:0] == 3'($past(chk_addr[2:0]) + 3'd1))
        else $error("write counter step wrong");
    a_data_ack: assert property (byte_end && q_r.st == ST_WDATA |=> sda_oe ##1 sda_oe) // R2
        else $error("data byte not acknowledged");
    a_rd_step: assert property (rd_load |=> chk_addr == 8'($past(chk_addr) + 8'h01)) // R14
        else $error("read counter step wrong");
    a_nak_quiet: assert property (fall && q_r.bitcnt == 4'd9 && q_r.st == ST_RDATA && !q_r.mack // R18
        && !start && !stop |=> q_r.st == ST_WAIT && !sda_oe)
        else $error("transmission continued after no-ack");
    a_wr_time: assert property (wr_busy |-> q_r.tmr < TW'(WR_CYCLES)) // R17
        else $error("write cycle overran");

    c_page_commit: cover property (stop && q_r.st == ST_WDATA && q_r.bufm == 8'hff);
    c_seq_read: cover property (rd_load && q_r.st == ST_RDATA);
    c_poll_busy: cover property (wr_busy && start);
    c_rand_read: cover property (rd_load && q_r.st == ST_ADDR);
endmodule
`default_nettype wire

// ### hw/eep_pkg.sv
// Constants and types shared by the two-wire memory slave
package eep_pkg;
    localparam logic [3:0]  DEV_TYPE      = 4'ha;
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          T_WR_MS       = 10;
    // Longest write time rounds down to whole clock cycles
    localparam int          WR_CYC        = (T_WR_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          PAGE_BYTES    = 8;
    localparam int          WORDS         = 2048;
    localparam logic        LINE_IDLE     = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WORD,
        ST_WDATA,
        ST_RDATA,
        ST_WAIT,
        ST_BUSY
    } eep_state_e;
endpackage

// ### hw/eep_sync.sv
// Two-flop synchroniser for one pin input
`timescale 1ns/1ns
`default_nettype none
module eep_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Pin and result
    input  wire logic pin_in,
    output logic      pin_sync
);
    typedef struct packed {
        logic meta;
        logic sync;
    } eep_sync_s;

    eep_sync_s q_r;
    eep_sync_s q_nxt;

    always_comb begin
        q_nxt      = q_r;
        q_nxt.meta = pin_in;
        q_nxt.sync = q_r.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q_r <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign pin_sync = q_r.sync;
endmodule
`default_nettype wire

// ### dv/eep_master.sv
// Bus master model that clocks transfers on the two-wire link
`timescale 1ns/1ns
`default_nettype none
module eep_master (
    // Clock
    input  wire logic sys_clk,
    // Link pins
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    // Clock stands high and data is released while no frame runs
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Data moves mid low phase, well clear of both clock edges
    task automatic bit_io(input logic b, output logic s);
        wt(5);
        sda_drv = b;
        wt(5);
        scl = 1'b1;
        wt(5);
        s = sda_line;
        wt(5);
        scl = 1'b0;
    endtask

    task automatic start;
        wt(5);
        sda_drv = 1'b1;
        wt(5);
        scl = 1'b1;
        wt(5);
        sda_drv = 1'b0;
        wt(5);
        scl = 1'b0;
    endtask

    task automatic stop;
        wt(5);
        sda_drv = 1'b0;
        wt(5);
        scl = 1'b1;
        wt(5);
        sda_drv = 1'b1;
        wt(10);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Last byte gets no acknowledge so the slave lets go of the line
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ns
`default_nettype none
module tb;
    import eep_pkg::*;
    localparam int WR_CYCLES = 400;
    logic       sys_clk;
    logic       sys_rst;
    logic       scl;
    logic       sda_drv;
    logic       sda_out;
    logic       sda_oe;
    logic       wr_busy;
    wire logic  sda_line;
    logic [7:0] exp_q[$];
    int         n_mismatch;
    int         comparisons;

    // Pull-up line, low whenever either party pulls it
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

    eep_slave #(.WR_CYCLES(WR_CYCLES)) eep_slave_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wr_busy(wr_busy));
    eep_master eep_master_inst (.sys_clk(sys_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sel(input logic [2:0] pg, input logic rw, input logic exp);
        logic a;
        eep_master_inst.start();
        eep_master_inst.wr_byte({DEV_TYPE, pg, rw}, a);
        chk("address ack", {7'h0, exp}, {7'h0, a});
    endtask

    task automatic wr_seq(input logic [2:0] pg, input logic [7:0] w, input logic [7:0] d0, input int n);
        logic a;
        sel(pg, 1'b0, 1'b1);
        eep_master_inst.wr_byte(w, a);
        chk("word ack", 8'h1, {7'h0, a});
        for (int k = 0; k < n; k++) begin
            eep_master_inst.wr_byte(d0 + 8'(k), a);
            chk("data ack", 8'h1, {7'h0, a});
        end
        eep_master_inst.stop();
    endtask

    // Bounded wait: the write must end within its cycle budget
    task automatic wait_idle;
        int n;
        n = 0;
        chk("busy", 8'h1, {7'h0, wr_busy});
        while (wr_busy === 1'b1 && n <= WR_CYCLES) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("busy end", 8'h0, {7'h0, wr_busy});
    endtask

    task automatic rd_at(input logic [2:0] pg, input logic [7:0] w);
        logic       a;
        logic [7:0] d;
        sel(pg, 1'b0, 1'b1);
        eep_master_inst.wr_byte(w, a);
        sel(pg, 1'b1, 1'b1);
        for (int j = 0; j < exp_q.size(); j++) begin
            eep_master_inst.rd_byte(j == exp_q.size() - 1, d);
            chk("read data", exp_q[j], d);
        end
        eep_master_inst.wt(6);
        chk("released", 8'h0, {7'h0, sda_oe});
        eep_master_inst.stop();
        exp_q = {};
    endtask

    task automatic t_poll;
        wr_seq(3'h2, 8'h00, 8'h5a, 1);
        sel(3'h2, 1'b0, 1'b0);
        eep_master_inst.stop();
        wait_idle();
        exp_q = {8'h5a};
        rd_at(3'h2, 8'h00);
    endtask

    // Ten bytes from slot 6: the last two land back on slots 6 and 7
    task automatic t_page;
        logic [7:0] d;
        wr_seq(3'h3, 8'h3e, 8'h80, 10);
        wait_idle();
        for (int j = 0; j < 7; j++) exp_q.push_back(8'h80 + 8'((j + 2) % 8 + (j >= 6 ? 8 : 0)));
        rd_at(3'h3, 8'h38);
        sel(3'h3, 1'b1, 1'b1);
        eep_master_inst.rd_byte(1'b1, d);
        chk("current read", 8'h89, d);
        eep_master_inst.stop();
    endtask

    // Word 0 of page 2 must still hold its own byte after page 1 word 0 is written
    task automatic t_wrap;
        wr_seq(3'h1, 8'hff, 8'h11, 1);
        wait_idle();
        wr_seq(3'h1, 8'h00, 8'h22, 1);
        wait_idle();
        exp_q = {8'h11, 8'h22};
        rd_at(3'h1, 8'hff);
        exp_q = {8'h5a};
        rd_at(3'h2, 8'h00);
    endtask

    task automatic t_refuse;
        logic a;
        eep_master_inst.start();
        eep_master_inst.wr_byte(8'h50, a);
        chk("foreign ack", 8'h0, {7'h0, a});
        eep_master_inst.stop();
        wr_seq(3'h0, 8'h20, 8'h00, 0);
        chk("busy", 8'h0, {7'h0, wr_busy});
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        sys_rst = 1'b1;
        n_mismatch = 0;
        comparisons = 0;
        repeat (20) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        eep_master_inst.wt(5);
        t_poll();
        t_page();
        t_wrap();
        t_refuse();
        stop_test();
    end
endmodule
`default_nettype wire
